/* File: spbg_map.vh */
// Register map and constants of the serial port baud generator.
// Included by the generator top and its sampler; definitions only.
`ifndef SPBG_MAP_VH
`define SPBG_MAP_VH
`define SPBG_OFF_RELOAD 12'h000
`define SPBG_OFF_TXCTRL 12'h004
`define SPBG_OFF_RXCTRL 12'h008
`define SPBG_OFF_STATUS 12'h00c
`define SPBG_OFF_INT_EN 12'h010
`define SPBG_OFF_INT_CLR 12'h014
`define SPBG_OFF_PWR 12'h018
`define SPBG_TX_CLKSRC_BIT 7
`define SPBG_TX_SYNC_BIT 4
`define SPBG_TX_HS_BIT 2
`define SPBG_TX_WMASK 8'hf5
`define SPBG_TX_RESET 8'h02
`define SPBG_RX_WMASK 8'hf8
`define SPBG_RX_RESET 8'h00
`define SPBG_RELOAD_RESET 8'h00
`define SPBG_PWR_SLEEP_BIT 0
`define SPBG_ST_TICK_BIT 0
`define SPBG_ST_RELOAD_BIT 1
`define SPBG_ST_RXCHG_BIT 2
`define SPBG_PRE_LOW 7'd64
`define SPBG_PRE_HIGH 7'd16
`define SPBG_PRE_SYNC 7'd4
`define SPBG_VOTES 3
`endif

/* File: spbg_remote.sv */
// Remote serial device: receive line and external bit clock.
// Driven through its tasks; the bit clock stays low outside bursts.
`timescale 1ns/1ps
module spbg_remote
(
    input wire pclk,
    output reg line,
    output reg sclk
);
initial
begin
    line = 1'b1;
    sclk = 1'b0;
end
task drive(input bit v, input int n);
    line <= v;
    repeat (n) @(posedge pclk);
endtask
task clocks(input int n);
    repeat (n)
    begin
        sclk <= 1'b1;
        repeat (2) @(posedge pclk);
        sclk <= 1'b0;
        repeat (2) @(posedge pclk);
    end
endtask
endmodule

/* File: spbg_top.v */
// Baud rate generator with control registers, APB slave and interrupt.
// Assumes an APB master on pclk; the receive line is synchronous to pclk.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "spbg_map.vh"
module spbg_top
#(
    parameter RELOAD_W = 8
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_clk_in,
    input wire receive_line_pin,
    output reg baud_tick,
    output wire sample_strobe,
    output wire rx_level,
    output wire irq
);
    reg [RELOAD_W-1:0] baud_reload_value_reg;
    reg [7:0] transmit_control_reg;
    reg [7:0] receive_control_reg;
    reg [0:0] power_reg;
    reg [2:0] int_status_reg;
    reg [2:0] int_enable_reg;
    reg [RELOAD_W-1:0] timer_reg;
    reg [6:0] pre_reg;
    reg ext_clk_reg;
    reg rx_level_d_reg;
    reg [6:0] pre_div;
    reg [6:0] samp_pos;
    wire wr;
    wire rd;
    wire reload_wr;
    wire sleeping;
    wire master;
    wire sync_mode;
    wire high_speed_select;
    wire pre_end;
    wire timer_ovf;
    wire ext_rise;
    wire tick_next;
    wire addr_ok;
    reg [2:0] events;

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign pready = 1'b1;
    assign addr_ok = (paddr == `SPBG_OFF_RELOAD) | (paddr == `SPBG_OFF_TXCTRL) |
                     (paddr == `SPBG_OFF_RXCTRL) | (paddr == `SPBG_OFF_STATUS) |
                     (paddr == `SPBG_OFF_INT_EN) | (paddr == `SPBG_OFF_INT_CLR) |
                     (paddr == `SPBG_OFF_PWR);
    assign pslverr = psel & penable & ~addr_ok;
    assign reload_wr = wr & (paddr == `SPBG_OFF_RELOAD);

    assign sleeping = power_reg[`SPBG_PWR_SLEEP_BIT];
    assign sync_mode = transmit_control_reg[`SPBG_TX_SYNC_BIT];
    assign master = ~sync_mode | transmit_control_reg[`SPBG_TX_CLKSRC_BIT];
    assign high_speed_select = transmit_control_reg[`SPBG_TX_HS_BIT];

    // Prescale per timer count
    always @*
    begin
        if (sync_mode)
            pre_div = `SPBG_PRE_SYNC;
        else if (high_speed_select)
            pre_div = `SPBG_PRE_HIGH;
        else
            pre_div = `SPBG_PRE_LOW;
    end

    // Sample the line three times around the middle of the last prescale period
    always @*
    begin
        samp_pos = pre_div >> 1;
    end

    assign pre_end = (pre_reg == pre_div - 7'd1) | (pre_reg >= pre_div);
    assign timer_ovf = pre_end & (timer_reg == {RELOAD_W{1'b0}});
    assign ext_rise = ext_clk_in & ~ext_clk_reg;
    // Slave mode follows the outside clock instead of the timer
    assign tick_next = sleeping ? 1'b0 : (master ? timer_ovf : ext_rise);

    // In master mode, three strobes per bit at the middle of the last prescale period
    assign sample_strobe = ~sleeping & master & (timer_reg == {RELOAD_W{1'b0}}) &
                           ((pre_reg == samp_pos - 7'd1) | (pre_reg == samp_pos) |
                            (pre_reg == samp_pos + 7'd1));

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg <= 7'h00;
            timer_reg <= {RELOAD_W{1'b0}};
            baud_tick <= 1'b0;
            ext_clk_reg <= 1'b0;
        end
        else
        begin
            ext_clk_reg <= ext_clk_in;
            baud_tick <= tick_next;
            if (reload_wr)
            begin
                pre_reg <= 7'h00;
                timer_reg <= pwdata[RELOAD_W-1:0];
            end
            else if (sleeping)
            begin
                // Frozen: no clock reaches the generator
                pre_reg <= pre_reg;
            end
            else if (pre_end)
            begin
                // Free-running down-count, reload on overflow; idle states keep counting
                pre_reg <= 7'h00;
                if (timer_reg == {RELOAD_W{1'b0}})
                    timer_reg <= baud_reload_value_reg;
                else
                    timer_reg <= timer_reg - {{(RELOAD_W-1){1'b0}}, 1'b1};
            end
            else
                pre_reg <= pre_reg + 7'h01;
        end
    end

    spbg_vote u_vote
    (
        .pclk(pclk),
        .presetn(presetn),
        .sample_strobe(sample_strobe),
        .line_in(receive_line_pin),
        .level_out(rx_level)
    );

    always @*
    begin
        events = 3'h0;
        events[`SPBG_ST_TICK_BIT] = tick_next;
        events[`SPBG_ST_RELOAD_BIT] = reload_wr;
        events[`SPBG_ST_RXCHG_BIT] = rx_level ^ rx_level_d_reg;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_reload_value_reg <= `SPBG_RELOAD_RESET;
            transmit_control_reg <= `SPBG_TX_RESET;
            receive_control_reg <= `SPBG_RX_RESET;
            power_reg <= 1'b0;
            int_status_reg <= 3'h0;
            int_enable_reg <= 3'h0;
            rx_level_d_reg <= 1'b1;
        end
        else
        begin
            rx_level_d_reg <= rx_level;
            if (reload_wr)
                baud_reload_value_reg <= pwdata[RELOAD_W-1:0];
            if (wr & (paddr == `SPBG_OFF_TXCTRL))
                transmit_control_reg <= (pwdata[7:0] & `SPBG_TX_WMASK) | `SPBG_TX_RESET;
            if (wr & (paddr == `SPBG_OFF_RXCTRL))
                receive_control_reg <= pwdata[7:0] & `SPBG_RX_WMASK;
            if (wr & (paddr == `SPBG_OFF_PWR))
                power_reg <= pwdata[0:0];
            if (wr & (paddr == `SPBG_OFF_INT_EN))
                int_enable_reg <= pwdata[2:0];
            // New events win over a simultaneous clear
            if (wr & (paddr == `SPBG_OFF_INT_CLR))
                int_status_reg <= (int_status_reg & ~pwdata[2:0]) | events;
            else
                int_status_reg <= int_status_reg | events;
        end
    end

    assign irq = |(int_status_reg & int_enable_reg);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd & ~penable)
        begin
            case (paddr)
                `SPBG_OFF_RELOAD: prdata <= {{(32-RELOAD_W){1'b0}}, baud_reload_value_reg};
                `SPBG_OFF_TXCTRL: prdata <= {24'h000000, transmit_control_reg};
                `SPBG_OFF_RXCTRL: prdata <= {24'h000000, receive_control_reg};
                `SPBG_OFF_STATUS: prdata <= {29'h00000000, int_status_reg};
                `SPBG_OFF_INT_EN: prdata <= {29'h00000000, int_enable_reg};
                `SPBG_OFF_PWR: prdata <= {31'h00000000, power_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

/* File: spbg_top_properties.sv */
// Port assertions for spbg_top, with a shadow of the written controls.
// Assumes APB writes take effect at the access edge.
`timescale 1ns/1ps
module spbg_props
#(
    parameter RELOAD_W = 8
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire ext_clk_in,
    input wire receive_line_pin,
    input wire baud_tick,
    input wire sample_strobe,
    input wire rx_level,
    input wire irq
);
reg [RELOAD_W-1:0] rel_reg;
reg [7:0] ctl_reg;
reg slp_reg;
reg en0_reg;
reg [1:0] stab_reg;
reg [15:0] gap_reg;
wire wr = psel && penable && pwrite;
wire mst = !ctl_reg[4] || ctl_reg[7];
wire [15:0] per = (ctl_reg[4] ? 16'h4 : ctl_reg[2] ? 16'h10 : 16'h40) * (16'h1 + rel_reg);
// Two ticks after a control write before judging, so a leftover tick is ignored
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rel_reg <= {RELOAD_W{1'b0}};
        ctl_reg <= 8'h02;
        slp_reg <= 1'b0;
        en0_reg <= 1'b1;
        stab_reg <= 2'h0;
        gap_reg <= 16'h0;
    end
    else
    begin
        gap_reg <= baud_tick ? 16'h0 : gap_reg + 16'h1;
        if (baud_tick && stab_reg != 2'h2)
            stab_reg <= stab_reg + 2'h1;
        if (wr && paddr == 12'h000)
            rel_reg <= pwdata[RELOAD_W-1:0];
        if (wr && paddr == 12'h004)
            ctl_reg <= pwdata[7:0];
        if (wr && paddr == 12'h010)
            en0_reg <= pwdata[2:0] == 3'h0;
        if (wr && paddr == 12'h018)
            slp_reg <= pwdata[0];
        if (wr && (paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h018))
            stab_reg <= 2'h0;
    end
end
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence two_high;
    (sample_strobe && receive_line_pin)[*2];
endsequence
sequence two_low;
    (sample_strobe && !receive_line_pin)[*2];
endsequence
chk_tick_single: assert property (baud_tick |=> !baud_tick)
    else $error("baud tick longer than one cycle");
chk_tick_period: assert property (baud_tick && stab_reg == 2'h2 && mst |-> gap_reg == per - 16'h1)
    else $error("tick period wrong for mode and reload");
chk_reload_restart: assert property (wr && paddr == 12'h000 |-> ##2 !baud_tick[*2])
    else $error("tick too soon after reload write");
chk_sleep_quiet: assert property (slp_reg && $past(slp_reg) && $past(slp_reg, 2) |-> !baud_tick)
    else $error("tick while asleep");
chk_slave_ext: assert property ($rose(ext_clk_in) && !mst && !slp_reg |-> ##[1:4] baud_tick)
    else $error("external clock edge gave no tick");
chk_slave_idle: assert property ((!mst && !ext_clk_in)[*6] |-> !baud_tick)
    else $error("internal tick in slave mode");
chk_vote_high: assert property (two_high |=> ##[0:2] rx_level)
    else $error("majority high not reported");
chk_vote_low: assert property (two_low |=> ##[0:2] !rx_level)
    else $error("majority low not reported");
chk_irq_masked: assert property (en0_reg |-> !irq)
    else $error("interrupt with all sources disabled");
chk_err_unmapped: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped access");
endmodule
bind spbg_top spbg_props #(.RELOAD_W(RELOAD_W)) u_spbg_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_in(ext_clk_in), .receive_line_pin(receive_line_pin), .baud_tick(baud_tick),
    .sample_strobe(sample_strobe), .rx_level(rx_level), .irq(irq));

/* File: spbg_top_tb.sv */
// Self-checking bench for spbg_top over APB.
// Assumes pready is sampled at the access edge.
`timescale 1ns/1ps
`include "spbg_map.vh"
module spbg_top_tb;
reg pclk, presetn, psel, penable, pwrite, e;
reg [11:0] paddr;
reg [31:0] pwdata, r;
wire [31:0] prdata;
wire pready, pslverr, ext_clk_in, receive_line_pin, baud_tick, sample_strobe, rx_level, irq;
int error_cnt, compares, n, ticks, strobes, t0, i, per;
reg [7:0] tc [0:4] = '{8'h00, 8'h00, 8'h04, 8'h90, 8'h94};
reg [7:0] tr [0:4] = '{8'hff, 8'h03, 8'h01, 8'h02, 8'h02};
int tp [0:4] = '{`SPBG_PRE_LOW, `SPBG_PRE_LOW, `SPBG_PRE_HIGH, `SPBG_PRE_SYNC, `SPBG_PRE_SYNC};
spbg_top u_spbg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .receive_line_pin(receive_line_pin), .baud_tick(baud_tick),
    .sample_strobe(sample_strobe), .rx_level(rx_level), .irq(irq));
spbg_remote u_spbg_remote (.pclk(pclk), .line(receive_line_pin), .sclk(ext_clk_in));
initial
begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
end
always @(posedge pclk) if (baud_tick === 1'b1) ticks <= ticks + 1;
always @(posedge pclk) if (sample_strobe === 1'b1) strobes <= strobes + 1;
task check(input [31:0] seen, input [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
endtask
task stop_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
endtask
task wait_tick;
    n = 0;
    do begin @(posedge pclk); n++; end while (baud_tick !== 1'b1);
endtask
initial
begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SPBG_OFF_RELOAD, 0); check(r, `SPBG_RELOAD_RESET, "reload reset");
    apb(0, `SPBG_OFF_TXCTRL, 0); check(r, `SPBG_TX_RESET, "txctrl reset");
    for (i = 0; i < 5; i++)
    begin
        per = tp[i] * (tr[i] + 1);
        apb(1, `SPBG_OFF_TXCTRL, tc[i]);
        apb(1, `SPBG_OFF_RELOAD, tr[i]);
        repeat (2) @(posedge pclk);
        // Timer restarts at the write edge, tick shows one cycle after overflow
        wait_tick; check(n, per - 1, "restart");
        wait_tick; check(n, per, "period");
    end
    apb(1, `SPBG_OFF_PWR, 1); repeat (2) @(posedge pclk); t0 = ticks; repeat (200) @(posedge pclk);
    check(ticks - t0, 0, "sleep ticks");
    apb(1, `SPBG_OFF_PWR, 0); apb(1, `SPBG_OFF_RELOAD, 2);
    wait_tick; wait_tick; check(n, 12, "wake period");
    apb(1, `SPBG_OFF_TXCTRL, 8'h10); repeat (3) @(posedge pclk); t0 = ticks;
    u_spbg_remote.clocks(5); repeat (8) @(posedge pclk);
    check(ticks - t0, 5, "slave ticks");
    check(irq, 0, "irq masked");
    apb(1, `SPBG_OFF_INT_EN, 1); @(posedge pclk); check(irq, 1, "irq raised");
    apb(1, `SPBG_OFF_INT_CLR, 1); @(posedge pclk); check(irq, 0, "irq cleared");
    apb(0, `SPBG_OFF_STATUS, 0); check(r[0], 0, "status cleared");
    apb(0, 12'hffc, 0); check(e, 1, "unmapped error");
    check(r, 0, "unmapped data");
    apb(1, `SPBG_OFF_TXCTRL, 0); apb(1, `SPBG_OFF_RELOAD, 0);
    @(posedge pclk); t0 = strobes;
    u_spbg_remote.drive(0, 256); check(strobes - t0, 12, "strobes in four bits");
    check(rx_level, 0, "vote low");
    u_spbg_remote.drive(1, 300); check(rx_level, 1, "vote high");
    // Second reset in mid-run must bring the reload back to zero
    apb(1, `SPBG_OFF_RELOAD, 8'h5a); presetn <= 1'b0; repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SPBG_OFF_RELOAD, 0); check(r, `SPBG_RELOAD_RESET, "reload after reset");
    stop_test;
end
initial
begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    stop_test;
end
endmodule

/* File: spbg_vote.v */
// Three-sample majority detector for the receive line.
// Assumes the line is already synchronous to pclk; strobe marks sample points.
`timescale 1ns/1ps
`include "spbg_map.vh"
module spbg_vote
(
    input wire pclk,
    input wire presetn,
    input wire sample_strobe,
    input wire line_in,
    output reg level_out
);
    reg [`SPBG_VOTES-1:0] samp_reg;
    wire [`SPBG_VOTES-1:0] samp_next;
    wire vote;

    assign samp_next = {samp_reg[`SPBG_VOTES-2:0], line_in};
    // Any two of three agree
    assign vote = (samp_next[0] & samp_next[1]) | (samp_next[1] & samp_next[2]) |
                  (samp_next[0] & samp_next[2]);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            samp_reg <= 3'h7;
            level_out <= 1'b1;
        end
        else if (sample_strobe)
        begin
            samp_reg <= samp_next;
            level_out <= vote;
        end
    end
endmodule
